// [rtl/rsc_regs.vh]
`ifndef RSC_REGS_VH
`define RSC_REGS_VH
`define RSC_ADDR_CTRL 4'hD
`define RSC_ADDR_FLAGS 4'hE
`define RSC_ADDR_CHG 4'hF
`define RSC_CTRL_RST 8'h18
`define RSC_FLAGS_RST 8'h80
`define RSC_CHG_RST 8'h00
`define RSC_CTRL_MASK 8'hBD
`define RSC_FLAGS_MASK 8'h81
`define RSC_B_HALT 7
`define RSC_B_BKUP 5
`define RSC_B_RATE_HI 4
`define RSC_B_RATE_LO 3
`define RSC_B_SEL 2
`define RSC_B_ALM_EN 0
`define RSC_B_STOP 7
`define RSC_B_ALM 0
`define RSC_CHG_KEY 4'hA
`define RSC_DIODE_NONE 2'h1
`define RSC_DIODE_ONE 2'h2
`define RSC_RATE_1HZ 2'h0
`define RSC_RATE_4K 2'h1
`define RSC_RATE_8K 2'h2
`define RSC_RATE_32K 2'h3
`define RSC_TAP_1HZ 14
`define RSC_TAP_4K 2
`define RSC_TAP_8K 1
`define RSC_DIV_W 15
`define RSC_VAR_COMBINED 2'h0
`define RSC_VAR_RESETPIN 2'h1
`define RSC_VAR_SPLIT 2'h2
`define RSC_BITS_PER_BYTE 3'h7
`define RSC_FIFO_W 12
`define RSC_FIFO_DEPTH 8
`define RSC_FIFO_AW 3
`endif

// [rtl/rsc_fifo.v]
`timescale 1ns/1ps
`default_nettype none
module rsc_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk, // Clock.
  input wire rst, // Asynchronous reset, active high.
  input wire in_valid, // Word offered.
  input wire [WIDTH-1:0] in_data, // Word in.
  output wire in_ready, // Room for a word.
  output wire out_valid, // Word available.
  output wire [WIDTH-1:0] out_data, // Oldest word.
  input wire out_ready // Drain takes the word.
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;

  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/rsc_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.vh"

// What this block does
// - Control bit 7 set halts the oscillator only on backup power.
// - Control bit 5 keeps wave/interrupt pins driven on backup power.
// - Bits 4:3 pick 1Hz, 4.096k, 8.192k or 32.768kHz; reset to 11.
// - Select bit 0 puts square wave on the pin, oscillator enabled only.
// - Select bit 1 routes alarm to pin; alarm flag always set on match.
// - Alarm enable gates the flag onto the pin; resets to 0.
// - Reset-pin variant: bits 5,4,3,2,0 are plain storage.
// - Split-pin variant: bit 2 low enables the square-wave pin.
// - Oscillator-stop flag sets when the oscillator goes from running to stopped.
// - Stop flag holds until written 0; writing 1 keeps it.
// - Alarm flag sets on match, cleared by writing 0 only.
// - Charger enabled only with key nibble 1010; register resets to zero.
// - Diode field 01 no diode, 10 one diode, else disabled.
// - Resistor field 01, 10, 11 pick resistor; 00 disables.
// - Input sampled on strobe edge, output changes on the shift edge.
// - Data out floats unless a read byte is loaded and selected.
// - One clock per bit, eight-bit groups, MSB first.
// - First byte is address; its MSB 1 means write, 0 read.
// - Address increments per byte; 4-bit wrap within read or write space.
// - Time copy refreshed at chip-select fall, or when power fail ends while selected.
// - Fixed-zero bits read as zero.
// - Power fail blocks all host accesses.
module rsc_top (
  input wire REF_CLK, // System clock, 100 MHz.
  input wire RST, // Asynchronous reset, active high.
  input wire CS_N, // Chip select from host, active low.
  input wire SCLK, // Shift clock from host.
  input wire DIN, // Serial data in.
  output wire DOUT_O, // Serial data out level.
  output wire DOUT_OE, // Serial data out enable.
  input wire SPI_CPHA, // Variant clock phase, 1 for modes 1 and 3.
  input wire [1:0] VARIANT, // Output pin variant.
  input wire PWR_FAIL, // Internal power-fail, on backup supply.
  input wire OSC_ACTIVE, // Oscillator running indication.
  input wire WAVE_32K, // 32.768 kHz from the oscillator.
  input wire ALARM_MATCH, // Alarm compare pulse.
  output wire SNAP_LOAD, // Refresh the readable time copy.
  output wire [3:0] TIME_RD_ADDR, // Time copy read address.
  input wire [7:0] TIME_RD_DATA, // Time copy read data.
  output wire TIME_WR_VALID, // Time register write offered.
  input wire TIME_WR_READY, // Time register write accepted.
  output wire [3:0] TIME_WR_ADDR, // Time register write address.
  output wire [7:0] TIME_WR_DATA, // Time register write data.
  output wire FIFO_IN_READY, // Write queue has room.
  output wire OSC_ENABLE, // Oscillator allowed to run.
  output wire WAVE_IRQ_OUT_O, // Shared output pin level.
  output wire WAVE_IRQ_OUT_OE, // Shared output pin pulls low.
  output wire IRQ_PIN_O, // Separate interrupt pin level.
  output wire IRQ_PIN_OE, // Separate interrupt pin pulls low.
  output wire CHG_ENABLE, // Trickle charger on.
  output wire CHG_DIODE, // Charger path has a diode.
  output wire [1:0] CHG_RES_SEL // Charger resistor choice.
);
  reg cs_m_ff, cs_s_ff;
  reg sclk_m_ff, sclk_s_ff, sclk_d_ff;
  reg din_m_ff, din_s_ff;
  reg osc_m_ff, osc_s_ff;
  reg w32_m_ff, w32_s_ff, w32_d_ff;
  reg sess_ff, snap_ff, cpol_ff;
  reg [2:0] bit_cnt_ff;
  reg [7:0] rx_ff, tx_ff;
  reg first_ff, dir_ff, fetch_ff, load_ff;
  reg [3:0] addr_ff;
  reg dout_ff, dout_en_ff;
  reg [7:0] ctrl_ff, flags_ff, chg_ff;
  reg run_ff, osc_en_ff;
  reg [`RSC_DIV_W-1:0] div_ff;
  reg pin_oe_ff, irq_oe_ff;
  reg chg_en_ff, chg_diode_ff;
  reg [1:0] chg_res_ff;
  reg [1:0] variant_m_ff;
  reg [1:0] variant_ff;
  reg cpha_m_ff;
  reg cpha_ff;
  reg [7:0] nxt_flags;
  reg nxt_pin_oe, nxt_irq_oe;
  reg wave;

  wire active, sclk_rise, sclk_fall, strobe_rise;
  wire strobe, shift_edge, byte_done;
  wire [7:0] nxt_rx;
  wire push_valid, fifo_ready;
  wire q_valid, q_ready, q_internal;
  wire [`RSC_FIFO_W-1:0] q_data;
  wire osc_en, run_now, osc_fall;
  wire wr_ctrl, wr_flags, wr_chg;
  wire bk_ok, irq_level;

  function [7:0] rd_mux;
    input [3:0] a;
    begin
      case (a)
        `RSC_ADDR_CTRL: rd_mux = ctrl_ff & `RSC_CTRL_MASK;
        `RSC_ADDR_FLAGS: rd_mux = flags_ff & `RSC_FLAGS_MASK;
        `RSC_ADDR_CHG: rd_mux = chg_ff;
        default: rd_mux = TIME_RD_DATA;
      endcase
    end
  endfunction

  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cs_m_ff <= 1'b1;
      cs_s_ff <= 1'b1;
      sclk_m_ff <= 1'b0;
      sclk_s_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
      din_m_ff <= 1'b0;
      din_s_ff <= 1'b0;
      osc_m_ff <= 1'b0;
      osc_s_ff <= 1'b0;
      w32_m_ff <= 1'b0;
      w32_s_ff <= 1'b0;
      w32_d_ff <= 1'b0;
      variant_m_ff <= `RSC_VAR_COMBINED;
      variant_ff <= `RSC_VAR_COMBINED;
      cpha_m_ff <= 1'b1;
      cpha_ff <= 1'b1;
    end else begin
      cs_m_ff <= CS_N;
      cs_s_ff <= cs_m_ff;
      sclk_m_ff <= SCLK;
      sclk_s_ff <= sclk_m_ff;
      sclk_d_ff <= sclk_s_ff;
      din_m_ff <= DIN;
      din_s_ff <= din_m_ff;
      osc_m_ff <= OSC_ACTIVE;
      osc_s_ff <= osc_m_ff;
      w32_m_ff <= WAVE_32K;
      w32_s_ff <= w32_m_ff;
      w32_d_ff <= w32_s_ff;
      variant_m_ff <= VARIANT;
      variant_ff <= variant_m_ff;
      cpha_m_ff <= SPI_CPHA;
      cpha_ff <= cpha_m_ff;
    end
  end

  // A power failure looks to the serial port exactly like a deselect.
  assign active = !cs_s_ff && !PWR_FAIL;
  assign sclk_rise = sclk_s_ff & !sclk_d_ff;
  assign sclk_fall = !sclk_s_ff & sclk_d_ff;
  // Idle clock level at select gives the polarity; phase comes from the variant.
  assign strobe_rise = !(cpol_ff ^ cpha_ff);
  assign strobe = sess_ff && active && (strobe_rise ? sclk_rise : sclk_fall);
  assign shift_edge = sess_ff && active && (strobe_rise ? sclk_fall : sclk_rise);
  assign nxt_rx = {rx_ff[6:0], din_s_ff};
  assign byte_done = strobe && (bit_cnt_ff == `RSC_BITS_PER_BYTE);
  assign push_valid = byte_done && !first_ff && dir_ff;

  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sess_ff <= 1'b0;
      snap_ff <= 1'b0;
      cpol_ff <= 1'b0;
      bit_cnt_ff <= 3'h0;
      rx_ff <= 8'h00;
      tx_ff <= 8'h00;
      first_ff <= 1'b1;
      dir_ff <= 1'b0;
      fetch_ff <= 1'b0;
      load_ff <= 1'b0;
      addr_ff <= 4'h0;
      dout_ff <= 1'b0;
      dout_en_ff <= 1'b0;
    end else begin
      sess_ff <= active;
      snap_ff <= active && !sess_ff;
      fetch_ff <= 1'b0;
      if (!active) begin
        bit_cnt_ff <= 3'h0;
        first_ff <= 1'b1;
        load_ff <= 1'b0;
        dout_en_ff <= 1'b0;
      end else if (!sess_ff) begin
        cpol_ff <= sclk_s_ff;
      end else begin
        if (strobe) begin
          rx_ff <= nxt_rx;
          bit_cnt_ff <= bit_cnt_ff + 3'h1;
        end
        if (byte_done) begin
          if (first_ff) begin
            first_ff <= 1'b0;
            dir_ff <= nxt_rx[7];
            addr_ff <= nxt_rx[3:0];
            fetch_ff <= !nxt_rx[7];
          end else begin
            // Only the low nibble counts, so each space wraps on itself.
            addr_ff <= addr_ff + 4'h1;
            fetch_ff <= !dir_ff;
          end
        end
        if (fetch_ff) begin
          tx_ff <= rd_mux(addr_ff);
          load_ff <= 1'b1;
          dout_en_ff <= 1'b1;
        end else if (shift_edge && load_ff) begin
          dout_ff <= tx_ff[7];
          tx_ff <= {tx_ff[6:0], 1'b0};
        end
      end
    end
  end

  assign DOUT_O = dout_ff;
  assign DOUT_OE = dout_en_ff;
  assign SNAP_LOAD = snap_ff;
  assign TIME_RD_ADDR = addr_ff;
  assign FIFO_IN_READY = fifo_ready;

  rsc_fifo #(
    .WIDTH(`RSC_FIFO_W),
    .DEPTH(`RSC_FIFO_DEPTH),
    .AW(`RSC_FIFO_AW)
  ) i_rsc_fifo (
    .clk(REF_CLK),
    .rst(RST),
    .in_valid(push_valid),
    .in_data({addr_ff, nxt_rx}),
    .in_ready(fifo_ready),
    .out_valid(q_valid),
    .out_data(q_data),
    .out_ready(q_ready)
  );

  // Writes to the three local registers drain at once; time writes wait.
  assign q_internal = (q_data[11:8] == `RSC_ADDR_CTRL) || (q_data[11:8] == `RSC_ADDR_FLAGS) ||
    (q_data[11:8] == `RSC_ADDR_CHG);
  assign q_ready = q_internal || TIME_WR_READY;
  assign TIME_WR_VALID = q_valid && !q_internal;
  assign TIME_WR_ADDR = q_data[11:8];
  assign TIME_WR_DATA = q_data[7:0];
  assign wr_ctrl = q_valid && (q_data[11:8] == `RSC_ADDR_CTRL);
  assign wr_flags = q_valid && (q_data[11:8] == `RSC_ADDR_FLAGS);
  assign wr_chg = q_valid && (q_data[11:8] == `RSC_ADDR_CHG);

  assign osc_en = !(ctrl_ff[`RSC_B_HALT] && PWR_FAIL);
  assign run_now = osc_s_ff && osc_en;
  assign osc_fall = run_ff && !run_now;

  // Hardware set wins over a software clear in the same cycle.
  always @* begin
    nxt_flags = flags_ff & `RSC_FLAGS_MASK;
    if (wr_flags && !q_data[`RSC_B_STOP]) begin
      nxt_flags[`RSC_B_STOP] = 1'b0;
    end
    if (wr_flags && !q_data[`RSC_B_ALM]) begin
      nxt_flags[`RSC_B_ALM] = 1'b0;
    end
    if (osc_fall) begin
      nxt_flags[`RSC_B_STOP] = 1'b1;
    end
    if (ALARM_MATCH) begin
      nxt_flags[`RSC_B_ALM] = 1'b1;
    end
  end

  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ctrl_ff <= `RSC_CTRL_RST;
      flags_ff <= `RSC_FLAGS_RST;
      chg_ff <= `RSC_CHG_RST;
      run_ff <= 1'b0;
      osc_en_ff <= 1'b1;
      div_ff <= {`RSC_DIV_W{1'b0}};
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= q_data[7:0] & `RSC_CTRL_MASK;
      end
      flags_ff <= nxt_flags;
      if (wr_chg) begin
        chg_ff <= q_data[7:0];
      end
      run_ff <= run_now;
      osc_en_ff <= osc_en;
      if (run_now && w32_s_ff && !w32_d_ff) begin
        div_ff <= div_ff + 1'b1;
      end
    end
  end

  always @* begin
    case ({ctrl_ff[`RSC_B_RATE_HI], ctrl_ff[`RSC_B_RATE_LO]})
      `RSC_RATE_1HZ: wave = div_ff[`RSC_TAP_1HZ];
      `RSC_RATE_4K: wave = div_ff[`RSC_TAP_4K];
      `RSC_RATE_8K: wave = div_ff[`RSC_TAP_8K];
      `RSC_RATE_32K: wave = w32_s_ff;
      default: wave = 1'b1;
    endcase
  end

  assign bk_ok = !PWR_FAIL || ctrl_ff[`RSC_B_BKUP];
  assign irq_level = flags_ff[`RSC_B_ALM] && ctrl_ff[`RSC_B_ALM_EN];

  // Open-drain pins: enable means pulling low.
  always @* begin
    nxt_pin_oe = 1'b0;
    nxt_irq_oe = 1'b0;
    case (variant_ff)
      `RSC_VAR_COMBINED: begin
        if (ctrl_ff[`RSC_B_SEL]) begin
          nxt_pin_oe = irq_level;
        end else begin
          nxt_pin_oe = osc_en && !wave;
        end
      end
      `RSC_VAR_SPLIT: begin
        nxt_pin_oe = !ctrl_ff[`RSC_B_SEL] && osc_en && !wave;
        nxt_irq_oe = irq_level;
      end
      `RSC_VAR_RESETPIN: begin
        nxt_pin_oe = 1'b0;
      end
      default: begin
        nxt_pin_oe = 1'b0;
      end
    endcase
    if (!bk_ok) begin
      nxt_pin_oe = 1'b0;
      nxt_irq_oe = 1'b0;
    end
  end

  always @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pin_oe_ff <= 1'b0;
      irq_oe_ff <= 1'b0;
      chg_en_ff <= 1'b0;
      chg_diode_ff <= 1'b0;
      chg_res_ff <= 2'h0;
    end else begin
      pin_oe_ff <= nxt_pin_oe;
      irq_oe_ff <= nxt_irq_oe;
      chg_en_ff <= (chg_ff[7:4] == `RSC_CHG_KEY) &&
        ((chg_ff[3:2] == `RSC_DIODE_NONE) || (chg_ff[3:2] == `RSC_DIODE_ONE)) &&
        (chg_ff[1:0] != 2'h0);
      chg_diode_ff <= (chg_ff[3:2] == `RSC_DIODE_ONE);
      chg_res_ff <= chg_ff[1:0];
    end
  end

  assign OSC_ENABLE = osc_en_ff;
  assign WAVE_IRQ_OUT_O = 1'b0;
  assign WAVE_IRQ_OUT_OE = pin_oe_ff;
  assign IRQ_PIN_O = 1'b0;
  assign IRQ_PIN_OE = irq_oe_ff;
  assign CHG_ENABLE = chg_en_ff;
  assign CHG_DIODE = chg_diode_ff;
  assign CHG_RES_SEL = chg_res_ff;
endmodule
`default_nettype wire

// [verification/rsc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module rsc_host (
  output logic cs_n, // Select, active low.
  output logic sclk, // Shift clock.
  output logic din, // Data to the device.
  input wire logic dout, // Resolved data line.
  input wire logic cpol, // Clock idle level.
  input wire logic cpha // Clock phase.
);
  localparam real H = 62.5;
  logic [7:0] wbuf [0:15];
  logic [7:0] rbuf [0:15];
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // The clock rests at its idle level between frames and the data line is inverted once released.
  task automatic xfer(input logic [7:0] addr, input int n);
    logic [7:0] sh;
    sclk = cpol;
    #(4*H);
    cs_n = 1'b0;
    #H;
    for (int k = 0; k <= n; k++) begin
      sh = (k == 0) ? addr : wbuf[k-1];
      for (int b = 7; b >= 0; b--) begin
        if (cpha) sclk = ~sclk;
        din = sh[b];
        #H;
        sclk = ~sclk;
        if (k > 0) rbuf[k-1][b] = dout;
        #H;
        if (!cpha) sclk = ~sclk;
      end
    end
    #H;
    cs_n = 1'b1;
    din = ~din;
    #(4*H);
  endtask
endmodule
`default_nettype wire

// [verification/rsc_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module rsc_checker (
  input wire logic REF_CLK, // Clock.
  input wire logic RST, // Reset.
  input wire logic CS_N, // Select.
  input wire logic PWR_FAIL, // Power fail.
  input wire logic DOUT_OE, // Data out enable.
  input wire logic SNAP_LOAD, // Time copy refresh.
  input wire logic OSC_ENABLE, // Oscillator allowed.
  input wire logic CHG_ENABLE, // Charger on.
  input wire logic [1:0] CHG_RES_SEL, // Resistor choice.
  input wire logic TIME_WR_VALID, // Time write offered.
  input wire logic [3:0] TIME_WR_ADDR, // Time write address.
  input wire logic WAVE_IRQ_OUT_O, // Shared pin level.
  input wire logic IRQ_PIN_O, // Interrupt pin level.
  input wire logic IRQ_PIN_OE, // Interrupt pin pull.
  input wire logic [1:0] VARIANT // Output pin variant.
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  snap_on_fall_a: assert property ($fell(CS_N) && !PWR_FAIL |-> ##[1:5] SNAP_LOAD) else $error("no refresh");
  snap_in_frame_a: assert property (SNAP_LOAD |-> !CS_N) else $error("refresh outside frame");
  snap_pulse_a: assert property (SNAP_LOAD |=> !SNAP_LOAD) else $error("refresh too long");
  dout_idle_a: assert property (CS_N [*6] |-> !DOUT_OE) else $error("data out driven while idle");
  pfail_dout_a: assert property (PWR_FAIL [*2] |-> !DOUT_OE) else $error("data out during power fail");
  osc_main_a: assert property (!PWR_FAIL [*2] |-> OSC_ENABLE) else $error("oscillator off on main");
  chg_res_a: assert property (CHG_ENABLE |-> CHG_RES_SEL != 2'h0) else $error("charger on without resistor");
  wr_time_a: assert property (TIME_WR_VALID |-> TIME_WR_ADDR < 4'hD) else $error("local register sent out");
  pin_drain_a: assert property (!WAVE_IRQ_OUT_O && !IRQ_PIN_O) else $error("output pin driven high");
  irq_split_only_a: assert property ((VARIANT != 2'h2) [*4] |-> !IRQ_PIN_OE) else $error("irq pin outside split");
  cover property (SNAP_LOAD);
  cover property (DOUT_OE);
  cover property (TIME_WR_VALID);
  cover property (CHG_ENABLE);
  cover property (IRQ_PIN_OE);
endmodule
bind rsc_top rsc_checker i_rsc_checker (.REF_CLK(REF_CLK), .RST(RST), .CS_N(CS_N), .PWR_FAIL(PWR_FAIL),
  .DOUT_OE(DOUT_OE), .SNAP_LOAD(SNAP_LOAD), .OSC_ENABLE(OSC_ENABLE), .CHG_ENABLE(CHG_ENABLE),
  .CHG_RES_SEL(CHG_RES_SEL), .TIME_WR_VALID(TIME_WR_VALID), .TIME_WR_ADDR(TIME_WR_ADDR),
  .WAVE_IRQ_OUT_O(WAVE_IRQ_OUT_O), .IRQ_PIN_O(IRQ_PIN_O), .IRQ_PIN_OE(IRQ_PIN_OE), .VARIANT(VARIANT));
`default_nettype wire

// [verification/rsc_top_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.vh"
module rsc_top_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cpha = 1'b0;
  logic cpol = 1'b0;
  logic pwr_fail = 1'b0;
  logic osc_active = 1'b1;
  logic wave_32k = 1'b0;
  logic alarm_match = 1'b0;
  logic time_wr_ready = 1'b1;
  logic [1:0] variant = 2'h0;
  logic dout_last = 1'b0;
  wire cs_n, sclk, din, dout_o, dout_oe, snap_load, time_wr_valid, fifo_in_ready, osc_enable;
  wire wave_o, wave_oe, irq_o, irq_oe, chg_enable, chg_diode;
  wire [1:0] chg_res_sel;
  wire [3:0] time_rd_addr, time_wr_addr;
  wire [7:0] time_wr_data;
  wire [7:0] time_rd_data = {4'h5, time_rd_addr};
  // No pull on the data line, so a released line shows the inverse of its last level.
  wire dout_line = dout_oe ? dout_o : ~dout_last;
  int err_count = 0;
  int check_count = 0;
  int cap_n = 0;
  logic [11:0] cap [0:15];
  rsc_top i_rsc_top (.REF_CLK(ref_clk), .RST(rst), .CS_N(cs_n), .SCLK(sclk), .DIN(din), .DOUT_O(dout_o),
    .DOUT_OE(dout_oe), .SPI_CPHA(cpha), .VARIANT(variant), .PWR_FAIL(pwr_fail), .OSC_ACTIVE(osc_active),
    .WAVE_32K(wave_32k), .ALARM_MATCH(alarm_match), .SNAP_LOAD(snap_load), .TIME_RD_ADDR(time_rd_addr),
    .TIME_RD_DATA(time_rd_data), .TIME_WR_VALID(time_wr_valid), .TIME_WR_READY(time_wr_ready),
    .TIME_WR_ADDR(time_wr_addr), .TIME_WR_DATA(time_wr_data), .FIFO_IN_READY(fifo_in_ready),
    .OSC_ENABLE(osc_enable), .WAVE_IRQ_OUT_O(wave_o), .WAVE_IRQ_OUT_OE(wave_oe), .IRQ_PIN_O(irq_o),
    .IRQ_PIN_OE(irq_oe), .CHG_ENABLE(chg_enable), .CHG_DIODE(chg_diode), .CHG_RES_SEL(chg_res_sel));
  rsc_host i_rsc_host (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout_line), .cpol(cpol), .cpha(cpha));
  always #5 ref_clk = ~ref_clk;
  always #200 wave_32k = ~wave_32k;
  always @(posedge ref_clk) begin
    if (dout_oe) dout_last <= dout_o;
    if (time_wr_valid && time_wr_ready) begin
      cap[cap_n] <= {time_wr_addr, time_wr_data};
      cap_n <= cap_n + 1;
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic reset;
    rst = 1'b1;
    tick(5);
    rst = 1'b0;
    tick(2);
  endtask
  task automatic wrx(input logic [7:0] a, input int n, input logic [31:0] d);
    for (int i = 0; i < n; i++) i_rsc_host.wbuf[i] = d[31-8*i -: 8];
    i_rsc_host.xfer(a, n);
    tick();
  endtask
  task automatic rdx(input logic [7:0] a, input int n, input logic [31:0] e);
    i_rsc_host.xfer(a, n);
    tick();
    for (int i = 0; i < n; i++) check(i_rsc_host.rbuf[i], e[31-8*i -: 8]);
  endtask
  task automatic pulses(input int len, output int n);
    logic p;
    n = 0;
    p = wave_oe;
    for (int t = 0; t < len; t++) begin
      tick();
      if (wave_oe && !p) n++;
      p = wave_oe;
    end
  endtask
  task automatic alarm;
    alarm_match = 1'b1;
    tick();
    alarm_match = 1'b0;
  endtask
  task automatic s_regs;
    rdx(8'h0D, 3, {`RSC_CTRL_RST, `RSC_FLAGS_RST, `RSC_CHG_RST, 8'h00});
    wrx(8'h8D, 3, 32'hFFFFA500);
    rdx(8'h0D, 3, 32'hBD80A500);
    wrx(8'h8E, 1, 32'h0);
    rdx(8'h0E, 1, 32'h0);
  endtask
  task automatic s_charger;
    logic [7:0] v [0:7] = '{8'hA5, 8'hA9, 8'hA6, 8'hAB, 8'hAD, 8'hA4, 8'h55, 8'hA1};
    logic en;
    for (int i = 0; i < 8; i++) begin
      wrx(8'h8F, 1, {v[i], 24'h0});
      en = v[i][7:4] == 4'hA && (v[i][3:2] == 2'h1 || v[i][3:2] == 2'h2) && v[i][1:0] != 2'h0;
      check(chg_enable, en);
      if (en) begin
        check(chg_diode, v[i][3:2] == 2'h2);
        check(chg_res_sel, v[i][1:0]);
      end
    end
  endtask
  task automatic s_alarm;
    check(wave_oe, 0);
    alarm();
    tick(3);
    check(wave_oe, 1);
    wrx(8'h8D, 1, 32'h84000000);
    check(wave_oe, 0);
    rdx(8'h0E, 1, 32'h01000000);
    wrx(8'h8E, 1, 32'h0);
    rdx(8'h0E, 1, 32'h0);
  endtask
  task automatic s_osc;
    wrx(8'h8D, 1, 32'h80000000);
    pwr_fail = 1'b1;
    tick(3);
    check(osc_enable, 0);
    wrx(8'h8F, 1, 32'h0);
    pwr_fail = 1'b0;
    tick(3);
    rdx(8'h0E, 2, 32'h80A10000);
    wrx(8'h8E, 1, 32'h0);
    osc_active = 1'b0;
    tick(10);
    osc_active = 1'b1;
    rdx(8'h0E, 1, 32'h80000000);
  endtask
  task automatic s_wave;
    logic [7:0] r [0:3] = '{8'h18, 8'h10, 8'h08, 8'h00};
    int d [0:3] = '{1, 4, 8, 32768};
    int n;
    for (int i = 0; i < 4; i++) begin
      wrx(8'h8D, 1, {r[i], 24'h0});
      pulses(1600, n);
      check(n >= 40 / d[i] - 1 && n <= 40 / d[i] + 1, 1);
    end
  endtask
  task automatic s_variant;
    int n;
    variant = `RSC_VAR_RESETPIN;
    reset();
    wrx(8'h8D, 1, 32'hFF000000);
    rdx(8'h0D, 1, 32'hBD000000);
    alarm();
    tick(3);
    check(wave_oe, 0);
    check(irq_oe, 0);
    wrx(8'h8D, 1, 32'h18000000);
    pulses(200, n);
    check(n, 0);
    variant = `RSC_VAR_SPLIT;
    reset();
    pulses(200, n);
    check(n >= 4, 1);
    wrx(8'h8D, 1, 32'h1D000000);
    pulses(200, n);
    check(n, 0);
    check(irq_oe, 0);
    alarm();
    tick(3);
    check(irq_oe, 1);
    check(wave_oe, 0);
    pwr_fail = 1'b1;
    tick(3);
    check(irq_oe, 0);
    pwr_fail = 1'b0;
    wrx(8'h8D, 1, 32'h3D000000);
    pwr_fail = 1'b1;
    tick(3);
    check(irq_oe, 1);
    pwr_fail = 1'b0;
    tick(3);
  endtask
  task automatic s_fifo;
    int b;
    b = cap_n;
    time_wr_ready = 1'b0;
    i_rsc_host.wbuf[0] = 8'hA5;
    for (int i = 0; i < 10; i++) i_rsc_host.wbuf[i+1] = 8'h20 + i[7:0];
    i_rsc_host.xfer(8'h8F, 11);
    check(fifo_in_ready, 0);
    time_wr_ready = 1'b1;
    for (int t = 0; t < 100 && cap_n < b + 8; t++) tick();
    if (cap_n < b + 8) begin
      err_count++;
      summarize();
    end
    tick(5);
    check(cap_n - b, 8);
    for (int i = 0; i < 8; i++) check(cap[b+i], {i[3:0], 8'h20 + i[7:0]});
    rdx(8'h0F, 2, 32'hA5500000);
  endtask
  initial begin
    for (int m = 0; m < 4; m++) begin
      tick();
      cpha = m[0];
      cpol = m[1];
      reset();
      s_regs();
    end
    s_charger();
    s_alarm();
    s_osc();
    reset();
    s_wave();
    s_fifo();
    s_variant();
    summarize();
  end
  initial begin
    #1000000;
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
